// *** core/lcs_pkg.sv ***
// shared constants, encodings and register map for the light-curtain indicator block
package lcs_pkg;

   // clock and time base
   localparam int CLK_HZ          = 10_000_000;
   localparam int CYC_PER_MS      = CLK_HZ / 1000;

   // operator reset switch hold window, ms
   localparam int RST_HOLD_MIN_MS = 250;
   localparam int RST_HOLD_MAX_MS = 2000;
   // exact multiples, so round-up and round-down agree
   localparam int RST_HOLD_MIN_CYC = RST_HOLD_MIN_MS * CYC_PER_MS;
   localparam int RST_HOLD_MAX_CYC = RST_HOLD_MAX_MS * CYC_PER_MS;

   // indicator timing, ms
   localparam int FLASH_SLOT_MS   = 125;
   localparam int LAMP_TEST_MS    = 2000;
   localparam int SCAN_SHOW_MS    = 2000;
   localparam int FLASH_SLOT_CYC  = FLASH_SLOT_MS * CYC_PER_MS;
   localparam int LAMP_TEST_CYC   = LAMP_TEST_MS * CYC_PER_MS;
   localparam int SCAN_SHOW_CYC   = SCAN_SHOW_MS * CYC_PER_MS;
   localparam int TIMER_W         = 25;

   // apb register byte offsets
   localparam logic [11:0] OFS_CTRL     = 12'h000;
   localparam logic [11:0] OFS_STATUS   = 12'h004;
   localparam logic [11:0] OFS_INT_STAT = 12'h008;
   localparam logic [11:0] OFS_INT_MASK = 12'h00C;

   // control register fields
   localparam int CTRL_LATCH_BIT   = 0;
   localparam int CTRL_EDM_ONE_BIT = 1;
   localparam int CTRL_RR_BIT      = 2;
   localparam int CTRL_SCAN_LSB    = 4;
   localparam int CTRL_SCAN_W      = 3;
   localparam int CTRL_DEFAULT_BIT = 8;

   // configuration defaults
   localparam logic       CTRL_LATCH_RST   = 1'b0;
   localparam logic       CTRL_EDM_ONE_RST = 1'b0;
   localparam logic       CTRL_RR_RST      = 1'b0;
   localparam logic [2:0] CTRL_SCAN_RST    = 3'h1;

   // status register fields
   localparam int STAT_IND_LSB     = 0;
   localparam int STAT_LATCHED_BIT = 4;
   localparam int STAT_LOCKOUT_BIT = 5;
   localparam int STAT_OUT_BIT     = 6;
   localparam int STAT_COUNT_LSB   = 8;

   // interrupt bits
   localparam int INT_W           = 4;
   localparam int INT_LOCKOUT_BIT = 0;
   localparam int INT_BLOCK_BIT   = 1;
   localparam int INT_RESET_BIT   = 2;
   localparam int INT_TEST_BIT    = 3;

   // power-up phases
   typedef enum logic [1:0] {
      PH_LAMP = 2'b00,
      PH_SCAN = 2'b01,
      PH_RUN  = 2'b10
   } lcs_phase_t;

   // active indication, also the display mode
   typedef enum logic [2:0] {
      IND_LAMP    = 3'b000,
      IND_SCAN    = 3'b001,
      IND_LOCKOUT = 3'b010,
      IND_TEST    = 3'b011,
      IND_SYNC    = 3'b100,
      IND_LATCH   = 3'b101,
      IND_BLOCKED = 3'b110,
      IND_CLEAR   = 3'b111
   } lcs_ind_t;

endpackage : lcs_pkg

// *** core/lcs_reset_qual.sv ***
// operator reset switch qualifier: hold-time window check
`timescale 1ns/1ps
`default_nettype none
module lcs_reset_qual
   import lcs_pkg::*;
#(
   parameter int MIN_CYC = RST_HOLD_MIN_CYC,
   parameter int MAX_CYC = RST_HOLD_MAX_CYC
) (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic reset_n_i,
   // synchronised switch level
   input  wire logic switch_i,
   // one-cycle valid reset
   output var  logic valid_o
);

   logic [TIMER_W-1:0] hold_cnt;
   logic               switch_d;
   wire  logic         released = switch_d & ~switch_i;
   wire  logic         saturated = (hold_cnt > TIMER_W'(MAX_CYC));

   // count held cycles; saturate past the window so a long press never qualifies
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         hold_cnt <= '0;
         switch_d <= 1'b0;
         valid_o  <= 1'b0;
      end else begin
         switch_d <= switch_i;
         valid_o  <= released && (hold_cnt >= TIMER_W'(MIN_CYC)) && !saturated;
         if (!switch_i)
            hold_cnt <= '0;
         else if (!saturated)
            hold_cnt <= hold_cnt + 1'b1;
      end
   end

endmodule : lcs_reset_qual
`default_nettype wire

// *** core/lcs_curtain.sv ***
// light-curtain indicator, latch and safety output logic with apb registers
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module lcs_curtain
   import lcs_pkg::*;
#(
   parameter int BEAMS       = 10,
   parameter int ZONES       = 8,
   parameter int RST_MIN_CYC = RST_HOLD_MIN_CYC,
   parameter int RST_MAX_CYC = RST_HOLD_MAX_CYC,
   parameter int FLASH_CYC   = FLASH_SLOT_CYC,
   parameter int LAMP_CYC    = LAMP_TEST_CYC,
   parameter int SCAN_CYC    = SCAN_SHOW_CYC
) (
   // clock and reset
   input  wire logic             clk_i,
   input  wire logic             reset_n_i,
   // apb slave
   input  wire logic             psel_i,
   input  wire logic             penable_i,
   input  wire logic             pwrite_i,
   input  wire logic [11:0]      paddr_i,
   input  wire logic [31:0]      pwdata_i,
   output var  logic [31:0]      prdata_o,
   output logic                  pready_o,
   output logic                  pslverr_o,
   // asynchronous field inputs
   input  wire logic [BEAMS-1:0] beam_blocked_i,
   input  wire logic             reset_switch_i,
   input  wire logic             test_input_open_i,
   input  wire logic             fault_i,
   // interrupt
   output logic                  irq_o,
   // guarded machine
   output var  logic [1:0]       safety_switching_output_o,
   // receiver indicators
   output var  logic             rx_status_red_o,
   output var  logic             rx_status_green_o,
   output var  logic             rx_reset_amber_o,
   output var  logic [ZONES-1:0] zone_red_o,
   output var  logic [ZONES-1:0] zone_green_o,
   output var  logic [2:0]       display_mode_o,
   output var  logic [7:0]       display_value_o,
   // emitter indicators
   output var  logic             tx_status_red_o,
   output var  logic             tx_status_green_o
);

   localparam int SYNC_W = BEAMS + 3;

   // two-stage synchronisers for every field input
   logic [SYNC_W-1:0] sync_a;
   logic [SYNC_W-1:0] sync_b;
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         sync_a <= '0;
         sync_b <= '0;
      end else begin
         sync_a <= {fault_i, test_input_open_i, reset_switch_i, beam_blocked_i};
         sync_b <= sync_a;
      end
   end
   wire logic [BEAMS-1:0] beam_s   = sync_b[BEAMS-1:0];
   wire logic             switch_s = sync_b[BEAMS];
   wire logic             test_s   = sync_b[BEAMS+1];
   wire logic             fault_s  = sync_b[BEAMS+2];

   // operator reset qualification
   logic valid_reset;
   lcs_reset_qual #(
      .MIN_CYC (RST_MIN_CYC),
      .MAX_CYC (RST_MAX_CYC)
   ) u_reset_qual (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .switch_i  (switch_s),
      .valid_o   (valid_reset)
   );

   // configuration register
   logic       cfg_latch;
   logic       cfg_edm_one;
   logic       cfg_rr;
   logic [2:0] cfg_scan;
   logic [INT_W-1:0] int_stat;
   logic [INT_W-1:0] int_mask;

   // apb decode; zero wait states, unmapped offsets answer with pslverr
   wire logic hit_ctrl  = (paddr_i == OFS_CTRL);
   wire logic hit_stat  = (paddr_i == OFS_STATUS);
   wire logic hit_istat = (paddr_i == OFS_INT_STAT);
   wire logic hit_imask = (paddr_i == OFS_INT_MASK);
   wire logic hit_any   = hit_ctrl | hit_stat | hit_istat | hit_imask;
   wire logic access    = psel_i & penable_i;
   wire logic wr_ctrl   = access & pwrite_i & hit_ctrl;
   wire logic wr_istat  = access & pwrite_i & hit_istat;
   wire logic wr_imask  = access & pwrite_i & hit_imask;
   wire logic cfg_dflt  = wr_ctrl & pwdata_i[CTRL_DEFAULT_BIT];
   assign pready_o  = 1'b1;
   assign pslverr_o = access & ~hit_any;

   // defaults at reset and on the restore-defaults command
   always_ff @(posedge clk_i) begin
      if (!reset_n_i || cfg_dflt) begin
         cfg_latch   <= CTRL_LATCH_RST;
         cfg_edm_one <= CTRL_EDM_ONE_RST;
         cfg_rr      <= CTRL_RR_RST;
         cfg_scan    <= CTRL_SCAN_RST;
      end else if (wr_ctrl) begin
         cfg_latch   <= pwdata_i[CTRL_LATCH_BIT];
         cfg_edm_one <= pwdata_i[CTRL_EDM_ONE_BIT];
         cfg_rr      <= pwdata_i[CTRL_RR_BIT];
         cfg_scan    <= pwdata_i[CTRL_SCAN_LSB +: CTRL_SCAN_W];
      end
   end

   // flash slot timer, shared by every blinking lamp
   logic [TIMER_W-1:0] slot_cnt;
   logic [2:0]         slot;
   wire  logic         slot_end = (slot_cnt == TIMER_W'(FLASH_CYC - 1));
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         slot_cnt <= '0;
         slot     <= 3'h0;
      end else begin
         slot_cnt <= slot_end ? '0 : slot_cnt + 1'b1;
         if (slot_end)
            slot <= slot + 3'h1;
      end
   end
   wire logic blink  = slot[0];
   wire logic single = (slot[2:1] == 2'b00);
   wire logic double = (slot == 3'h0) | (slot == 3'h2);

   // power-up sequence: lamp test, then scan code, then run
   lcs_phase_t         phase;
   logic [TIMER_W-1:0] ph_cnt;
   wire  logic lamp_done = (phase == PH_LAMP) && (ph_cnt == TIMER_W'(LAMP_CYC - 1));
   wire  logic scan_done = (phase == PH_SCAN) && (ph_cnt == TIMER_W'(SCAN_CYC - 1));
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         phase  <= PH_LAMP;
         ph_cnt <= '0;
      end else begin
         case (phase)
            PH_LAMP: begin
               ph_cnt <= lamp_done ? '0 : ph_cnt + 1'b1;
               if (lamp_done)
                  phase <= PH_SCAN;
            end
            PH_SCAN: begin
               ph_cnt <= scan_done ? '0 : ph_cnt + 1'b1;
               if (scan_done)
                  phase <= PH_RUN;
            end
            default: begin
               ph_cnt <= '0;
               phase  <= PH_RUN;
            end
         endcase
      end
   end
   wire logic running = (phase == PH_RUN);

   // beam analysis: zone occupancy and blocked count
   function automatic logic [7:0] count_ones(input logic [BEAMS-1:0] v);
      logic [7:0] n;
      n = 8'h00;
      for (int b = 0; b < BEAMS; b++)
         n = n + {7'h00, v[b]};
      return n;
   endfunction

   logic [ZONES-1:0] zone_blk;
   for (genvar z = 0; z < ZONES; z++) begin : g_zone
      always_comb begin
         zone_blk[z] = 1'b0;
         for (int b = 0; b < BEAMS; b++)
            if ((b * ZONES) / BEAMS == z)
               zone_blk[z] = zone_blk[z] | beam_s[b];
      end
   end
   wire logic       any_blk   = |beam_s;
   wire logic       sync_blk  = beam_s[0];
   wire logic [7:0] blk_count = count_ones(beam_s);

   // lockout and latch state
   logic lockout;
   logic latched;
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         lockout <= 1'b0;
         latched <= 1'b1;
      end else begin
         if (fault_s)
            lockout <= 1'b1;
         else if (valid_reset)
            lockout <= 1'b0;
         // a beam break sets the latch; a reset only clears it when all clear
         if (any_blk || lockout || test_s)
            latched <= 1'b1;
         else if (valid_reset && running)
            latched <= 1'b0;
      end
   end

   // indication priority, power-up phases first, then lockout
   wire lcs_ind_t ind =
        (phase == PH_LAMP)          ? IND_LAMP    :
        (phase == PH_SCAN)          ? IND_SCAN    :
        lockout                     ? IND_LOCKOUT :
        test_s                      ? IND_TEST    :
        sync_blk                    ? IND_SYNC    :
        any_blk                     ? IND_BLOCKED :
        (cfg_latch && latched)      ? IND_LATCH   :
                                      IND_CLEAR;

   wire logic next_out = running && !lockout && !test_s && !any_blk
                         && (!cfg_latch || !latched);

   // next indicator values for the receiver
   logic             next_red;
   logic             next_green;
   logic             next_amber;
   logic [ZONES-1:0] next_zr;
   logic [ZONES-1:0] next_zg;
   logic [7:0]       next_value;
   always_comb begin
      next_red   = 1'b0;
      next_green = 1'b0;
      next_amber = 1'b0;
      next_zr    = '0;
      next_zg    = '0;
      next_value = 8'h00;
      case (ind)
         IND_LAMP: begin
            next_red   = blink;
            next_green = ~blink;
            next_amber = blink;
            next_zr    = {ZONES{blink}};
            next_zg    = {ZONES{~blink}};
            next_value = 8'hFF;
         end
         IND_SCAN: next_value = {5'h00, cfg_scan};
         IND_LOCKOUT: next_red = single;
         IND_TEST: begin
            next_red   = 1'b1;
            next_zr    = {ZONES{1'b1}};
            next_value = 8'(BEAMS - 1);
            if (BEAMS == 10) begin
               next_zr[0] = 1'b0;
               next_zg[0] = 1'b1;
            end
         end
         IND_SYNC: begin
            next_red   = 1'b1;
            next_zr[0] = 1'b1;
         end
         IND_BLOCKED: begin
            next_red   = 1'b1;
            next_amber = 1'b1;
            next_zr    = zone_blk;
            next_zg    = ~zone_blk;
            next_value = blk_count;
         end
         IND_LATCH: begin
            next_red   = 1'b1;
            next_amber = double;
            next_zg    = {ZONES{1'b1}};
         end
         default: begin
            next_green = cfg_rr ? blink : 1'b1;
            next_amber = 1'b1;
            next_zg    = {ZONES{1'b1}};
         end
      endcase
   end

   // emitter status lamp
   wire logic next_tx_red   = (phase == PH_LAMP) ? blink : (lockout & single);
   wire logic next_tx_green = (phase == PH_LAMP) ? ~blink :
                              lockout ? 1'b0 : test_s ? blink : 1'b1;

   // all lamp, display and output drivers come from flops
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         rx_status_red_o           <= 1'b0;
         rx_status_green_o         <= 1'b0;
         rx_reset_amber_o          <= 1'b0;
         zone_red_o                <= '0;
         zone_green_o              <= '0;
         display_mode_o            <= IND_LAMP;
         display_value_o           <= 8'h00;
         tx_status_red_o           <= 1'b0;
         tx_status_green_o         <= 1'b0;
         safety_switching_output_o <= 2'b00;
      end else begin
         rx_status_red_o           <= next_red;
         rx_status_green_o         <= next_green;
         rx_reset_amber_o          <= next_amber;
         zone_red_o                <= next_zr;
         zone_green_o              <= next_zg;
         display_mode_o            <= ind;
         display_value_o           <= next_value;
         tx_status_red_o           <= next_tx_red;
         tx_status_green_o         <= next_tx_green;
         safety_switching_output_o <= {2{next_out}};
      end
   end

   // interrupt events
   logic ind_blk_d;
   logic lockout_d;
   logic test_d;
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         ind_blk_d <= 1'b0;
         lockout_d <= 1'b0;
         test_d    <= 1'b0;
      end else begin
         ind_blk_d <= any_blk;
         lockout_d <= lockout;
         test_d    <= test_s;
      end
   end
   logic [INT_W-1:0] int_evt;
   always_comb begin
      int_evt                  = '0;
      int_evt[INT_LOCKOUT_BIT] = lockout & ~lockout_d;
      int_evt[INT_BLOCK_BIT]   = any_blk & ~ind_blk_d & running;
      int_evt[INT_RESET_BIT]   = valid_reset;
      int_evt[INT_TEST_BIT]    = test_s & ~test_d;
   end

   // sticky status, write one to clear; a new event beats the clear
   wire logic [INT_W-1:0] w1c = wr_istat ? pwdata_i[INT_W-1:0] : '0;
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         int_stat <= '0;
         int_mask <= '0;
      end else begin
         int_stat <= (int_stat & ~w1c) | int_evt;
         if (wr_imask)
            int_mask <= pwdata_i[INT_W-1:0];
      end
   end
   assign irq_o = |(int_stat & int_mask);

   // read data captured in the setup cycle, stable through the access phase
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_ctrl) begin
         rd_mux[CTRL_LATCH_BIT]                 = cfg_latch;
         rd_mux[CTRL_EDM_ONE_BIT]               = cfg_edm_one;
         rd_mux[CTRL_RR_BIT]                    = cfg_rr;
         rd_mux[CTRL_SCAN_LSB +: CTRL_SCAN_W]   = cfg_scan;
      end else if (hit_stat) begin
         rd_mux[STAT_IND_LSB +: 3]              = ind;
         rd_mux[STAT_LATCHED_BIT]               = latched;
         rd_mux[STAT_LOCKOUT_BIT]               = lockout;
         rd_mux[STAT_OUT_BIT]                   = safety_switching_output_o[0];
         rd_mux[STAT_COUNT_LSB +: 8]            = blk_count;
      end else if (hit_istat) begin
         rd_mux[INT_W-1:0]                      = int_stat;
      end else if (hit_imask) begin
         rd_mux[INT_W-1:0]                      = int_mask;
      end
   end
   always_ff @(posedge clk_i) begin
      if (!reset_n_i)
         prdata_o <= 32'h0000_0000;
      else if (psel_i && !penable_i)
         prdata_o <= rd_mux;
   end

endmodule : lcs_curtain
`default_nettype wire

// *** verif/lcs_sva.sv ***
// concurrent checks on the curtain indicator ports
`timescale 1ns/1ps
`default_nettype none
module lcs_sva
   import lcs_pkg::*;
#(
   parameter int BEAMS = 10,
   parameter int ZONES = 8
) (
   // clock and reset
   input wire logic             clk_i,
   input wire logic             reset_n_i,
   // apb
   input wire logic             psel_i,
   input wire logic             penable_i,
   input wire logic [11:0]      paddr_i,
   input wire logic             pslverr_o,
   // field side and lamps
   input wire logic [BEAMS-1:0] beam_blocked_i,
   input wire logic [1:0]       safety_switching_output_o,
   input wire logic             rx_status_red_o,
   input wire logic             rx_status_green_o,
   input wire logic             rx_reset_amber_o,
   input wire logic [ZONES-1:0] zone_red_o,
   input wire logic [ZONES-1:0] zone_green_o,
   input wire logic [2:0]       display_mode_o,
   input wire logic [7:0]       display_value_o,
   input wire logic             tx_status_red_o,
   input wire logic             tx_status_green_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);

   // only four aligned words are mapped
   wire logic unmapped = (paddr_i > 12'h00C) || (paddr_i[1:0] != 2'b00);

   // steady beams let the count settle through the sync chain
   sequence s_steady;
      $stable(beam_blocked_i) [*5];
   endsequence
   sequence s_lamp_end;
      display_mode_o == IND_LAMP ##1 display_mode_o != IND_LAMP;
   endsequence

   property p_powerup;
      $rose(reset_n_i) |-> (display_mode_o == IND_LAMP) [*8];
   endproperty
   a_powerup: assert property (p_powerup)
      else $error("lamp test missing after reset");
   property p_lamp_scan;
      s_lamp_end |-> display_mode_o == IND_SCAN;
   endproperty
   a_lamp_scan: assert property (p_lamp_scan)
      else $error("scan code not shown after lamp test");
   property p_lockout;
      display_mode_o == IND_LOCKOUT |-> zone_red_o == '0 && zone_green_o == '0 && !rx_reset_amber_o
         && !rx_status_green_o && safety_switching_output_o == 2'b00;
   endproperty
   a_lockout: assert property (p_lockout)
      else $error("lockout lamps wrong");
   property p_clear;
      display_mode_o == IND_CLEAR |-> rx_reset_amber_o && (&zone_green_o) && zone_red_o == '0
         && !rx_status_red_o && tx_status_green_o && !tx_status_red_o;
   endproperty
   a_clear: assert property (p_clear)
      else $error("clear lamps wrong");
   property p_blocked;
      s_steady ##0 display_mode_o == IND_BLOCKED |-> rx_status_red_o && rx_reset_amber_o
         && zone_red_o != '0 && display_value_o == 8'($countones(beam_blocked_i));
   endproperty
   a_blocked: assert property (p_blocked)
      else $error("blocked lamps or count wrong");
   property p_sync;
      display_mode_o == IND_SYNC |-> zone_red_o == ZONES'(1) && zone_green_o == '0 && rx_status_red_o;
   endproperty
   a_sync: assert property (p_sync)
      else $error("beam one indication wrong");
   property p_test;
      display_mode_o == IND_TEST |-> display_value_o == 8'(BEAMS - 1) && zone_green_o == ZONES'(1)
         && zone_red_o == ~zone_green_o;
   endproperty
   a_test: assert property (p_test)
      else $error("test mode display wrong");
   property p_latch;
      display_mode_o == IND_LATCH |-> rx_status_red_o && !rx_status_green_o && (&zone_green_o)
         && safety_switching_output_o == 2'b00;
   endproperty
   a_latch: assert property (p_latch)
      else $error("latch lamps or outputs wrong");
   property p_outputs;
      safety_switching_output_o != 2'b00 |-> safety_switching_output_o == 2'b11
         && display_mode_o == IND_CLEAR;
   endproperty
   a_outputs: assert property (p_outputs)
      else $error("outputs on outside clear state");
   property p_slverr;
      psel_i && penable_i |-> pslverr_o == unmapped;
   endproperty
   a_slverr: assert property (p_slverr)
      else $error("error response wrong");
endmodule : lcs_sva

bind lcs_curtain lcs_sva u_sva (.clk_i, .reset_n_i, .psel_i, .penable_i,
   .paddr_i, .pslverr_o, .beam_blocked_i, .safety_switching_output_o, .rx_status_red_o, .rx_status_green_o,
   .rx_reset_amber_o, .zone_red_o, .zone_green_o, .display_mode_o, .display_value_o, .tx_status_red_o,
   .tx_status_green_o);
`default_nettype wire

// *** verif/lcs_operator.sv ***
// operator reset switch model
`timescale 1ns/1ps
`default_nettype none
module lcs_operator (
   // clock
   input  wire logic clk_i,
   // switch level, 1 = closed
   output var  logic reset_switch_o
);
   initial reset_switch_o = 1'b0;

   // close for n cycles then open; n outside the window is a misuse on purpose
   task automatic press(input int n);
      @(posedge clk_i);
      reset_switch_o <= 1'b1;
      repeat (n) @(posedge clk_i);
      reset_switch_o <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask : press
endmodule : lcs_operator
`default_nettype wire

// *** verif/tb_lcs_curtain.sv ***
// self-checking bench for the curtain indicator block
`timescale 1ns/1ps
`default_nettype none
module tb_lcs_curtain
   import lcs_pkg::*;
;
   localparam int BEAMS = 10;
   localparam int ZONES = 8;
   logic             clk = 1'b0;
   logic             reset_n, psel, penable, pwrite, sw, test_open, fault;
   logic             pready, pslverr, irq, err, st_red, st_green, amber, tx_red, tx_green;
   logic [11:0]      paddr;
   logic [31:0]      pwdata, prdata, rd, s;
   logic [BEAMS-1:0] beams, bb;
   logic [1:0]       safe;
   logic [ZONES-1:0] z_red, z_green;
   logic [2:0]       mode;
   logic [7:0]       value;
   int               fail_count, compares, h;

   // 10 MHz clock
   always #50 clk = ~clk;

   // short counts keep the run brief
   // widths stay at their defaults, which the local BEAMS and ZONES mirror
   lcs_curtain #(.RST_MIN_CYC(4), .RST_MAX_CYC(20), .FLASH_CYC(4),
      .LAMP_CYC(16), .SCAN_CYC(16)) dut (.clk_i(clk), .reset_n_i(reset_n), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .beam_blocked_i(beams), .reset_switch_i(sw),
      .test_input_open_i(test_open), .fault_i(fault), .irq_o(irq), .safety_switching_output_o(safe),
      .rx_status_red_o(st_red), .rx_status_green_o(st_green), .rx_reset_amber_o(amber),
      .zone_red_o(z_red), .zone_green_o(z_green), .display_mode_o(mode), .display_value_o(value),
      .tx_status_red_o(tx_red), .tx_status_green_o(tx_green));
   lcs_operator op (.clk_i(clk), .reset_switch_o(sw));

   // expectation helpers
   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction : xs
   function automatic logic [7:0] zmap(input logic [BEAMS-1:0] b);
      logic [7:0] z;
      z = 8'h00;
      for (int i = 0; i < BEAMS; i++) if (b[i]) z[i*ZONES/BEAMS] = 1'b1;
      return z;
   endfunction : zmap

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : settle
   // inputs pass two sync flops and an output flop
   task automatic field(input logic [BEAMS-1:0] b, input logic t, input logic f);
      @(posedge clk);
      beams <= b;
      test_open <= t;
      fault <= f;
      settle(6);
   endtask : field
   // lamp on-time over one 32-cycle flash period
   task automatic count(input int which, output int n);
      n = 0;
      repeat (32) begin
         @(negedge clk);
         n += (which == 0) ? tx_green : (which == 1) ? amber : (which == 2) ? st_red : st_green;
      end
   endtask : count
   // apb master: holds the request until pready is seen high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) fail_count++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic print_verdict;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : print_verdict

   // main sequence
   initial begin
      {reset_n, psel, penable, pwrite, test_open, fault} = '0;
      paddr = '0;
      pwdata = '0;
      beams = '0;
      s = 32'hD124;
      repeat (4) @(posedge clk);
      reset_n <= 1'b1;
      @(negedge clk);
      chk("mode", mode, IND_LAMP);
      apb(1'b0, OFS_CTRL, 32'h0);
      chk("ctrl", rd, 32'h10);
      apb(1'b0, 12'h010, 32'h0);
      chk("bad err", err, 1);
      chk("bad rd", rd, 0);
      settle(14);
      chk("mode", mode, IND_SCAN);
      chk("scan", value, 1);
      settle(20);
      chk("mode", mode, IND_CLEAR);
      chk("zg", z_green, 8'hFF);
      chk("amber", amber, 1);
      chk("green", st_green, 1);
      chk("tx", {tx_red, tx_green}, 1);
      chk("out", safe, 3);
      for (int i = 0; i < 8; i++) begin
         s = xs(s);
         bb = (i == 0) ? 10'h3FE : (i == 1) ? 10'h200 : (s[9:0] | 10'h002) & 10'h3FE;
         field(bb, 1'b0, 1'b0);
         chk("mode", mode, IND_BLOCKED);
         chk("cnt", value, $countones(bb));
         chk("zr", z_red, zmap(bb));
         chk("lamp", {st_red, amber}, 3);
      end
      field(10'h041, 1'b0, 1'b0);
      chk("mode", mode, IND_SYNC);
      chk("zones", {z_red, z_green}, 16'h0100);
      field('0, 1'b1, 1'b0);
      chk("mode", mode, IND_TEST);
      chk("val", value, BEAMS - 1);
      chk("zones", {z_red, z_green}, 16'hFE01);
      count(0, h);
      chk("tx blink", h, 16);
      apb(1'b1, OFS_INT_MASK, 32'h1);
      field('1, 1'b1, 1'b1);
      chk("mode", mode, IND_LOCKOUT);
      chk("dark", {z_red, z_green, amber, safe}, 0);
      count(2, h);
      chk("red flash", h, 8);
      chk("irq", irq, 1);
      apb(1'b1, OFS_INT_STAT, 32'h1);
      @(negedge clk);
      chk("irq", irq, 0);
      field('0, 1'b0, 1'b0);
      chk("mode", mode, IND_LOCKOUT);
      op.press(8);
      settle(6);
      chk("mode", mode, IND_CLEAR);
      apb(1'b1, OFS_CTRL, 32'h11);
      field(10'h004, 1'b0, 1'b0);
      field('0, 1'b0, 1'b0);
      chk("mode", mode, IND_LATCH);
      chk("lamps", {st_red, st_green, z_green, safe}, 12'hBFC);
      count(1, h);
      chk("amber dbl", h, 8);
      op.press(2);
      settle(6);
      chk("short", mode, IND_LATCH);
      op.press(30);
      settle(6);
      chk("long", mode, IND_LATCH);
      op.press(8);
      settle(6);
      chk("mode", mode, IND_CLEAR);
      chk("out", safe, 3);
      apb(1'b1, OFS_CTRL, 32'h15);
      settle(2);
      count(3, h);
      chk("rr blink", h, 16);
      apb(1'b1, OFS_CTRL, 32'h100);
      apb(1'b0, OFS_CTRL, 32'h0);
      chk("ctrl", rd, 32'h10);
      print_verdict();
   end

   // watchdog far beyond the expected run
   initial begin
      #2_000_000;
      fail_count++;
      print_verdict();
   end
endmodule : tb_lcs_curtain
`default_nettype wire
